/* hdl/asl_adapter.sv */
/*
  Adapter end of the serial link: character framing, header and checksum,
  flow control, frame gap detection, response timer and reset input.
  Assumes link inputs are synchronous to i_mclk and the user keeps the
  transmit FIFO fed during a frame.
*/
`timescale 1ns/100ps
`include "asl_cfg.svh"
module asl_adapter import asl_pkg::*; #(
  parameter logic [23:0] GAP_CYC  = 24'(`ASL_GAP_CYC),
  parameter logic [23:0] RESP_CYC = 24'(`ASL_RESP_CYC),
  parameter int          DEPTH    = `ASL_FIFO_DEPTH,
  parameter logic [10:0] DIV_HI   = 11'(`ASL_DIV_HI - 1)
) (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // link
  asl_if.adapter          lk,
  // configuration
  input  wire logic       i_baud_hi,
  // transmit data part
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_last,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  // receive data part
  input  wire logic       i_rx_hold,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_done,
  output logic            o_rx_good,
  output logic            o_frame_err,
  // status
  output logic            o_resp_timeout,
  output logic            o_tx_hold,
  output logic            o_reset_start
);
  localparam logic [10:0] DIV_LO = 11'(`ASL_DIV_LO - 1);

  logic        halt;
  logic        rst_q;
  logic [10:0] div_cnt;
  logic        tick;
  logic [10:0] tx_sh;
  logic [3:0]  tx_bits;
  logic [3:0]  tx_ph;
  logic        tx_busy;
  logic        tx_load;
  logic [7:0]  tx_byte;
  asl_txst_t   st;
  logic [7:0]  tx_sum;
  logic        tx_end;
  logic [8:0]  fifo_q;
  logic        fifo_v;
  logic        fifo_rd;
  logic [10:0] rx_sh;
  logic [3:0]  rx_bits;
  logic [3:0]  rx_ph;
  logic        rx_done;
  logic [7:0]  rx_byte;
  logic        rx_bad_char;
  logic [23:0] gap_cnt;
  logic        in_frame;
  logic        hdr_bad;
  logic        bad;
  logic [7:0]  rx_sum;
  logic        have_pend;
  logic [7:0]  pend;
  logic        rx_end;
  logic        good_end;
  logic [23:0] resp_cnt;
  logic        pending;

  assign halt = !lk.h_rst_n;
  assign o_tx_hold = (resp_cnt != '0);

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rst_q         <= 1'b1;
      o_reset_start <= 1'b0;
    end else begin
      rst_q         <= lk.h_rst_n;
      o_reset_start <= lk.h_rst_n && !rst_q;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else if (div_cnt == '0) begin
      div_cnt <= i_baud_hi ? DIV_HI : DIV_LO;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt - 1'b1;
      tick    <= 1'b0;
    end
  end

  // queue decouples the user from the character timing
  asl_fifo #(.W(`ASL_FIFO_WIDTH), .D(DEPTH)) u_txq (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_wr_data  ({i_tx_last, i_tx_data}),
    .i_wr_valid (i_tx_valid),
    .o_wr_ready (o_tx_ready),
    .o_rd_data  (fifo_q),
    .o_rd_valid (fifo_v),
    .i_rd_ready (fifo_rd)
  );

  assign tx_busy = (tx_bits != '0);
  assign lk.a_txd = tx_sh[0];
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      tx_sh   <= '1;
      tx_bits <= '0;
      tx_ph   <= '0;
    end else if (halt) begin
      tx_sh   <= '1;
      tx_bits <= '0;
      tx_ph   <= '0;
    end else if (tx_load) begin
      // start, LSB first, even parity, stop
      tx_sh   <= {1'b1, ^tx_byte, tx_byte, 1'b0};
      tx_bits <= `ASL_CHAR_BITS;
      tx_ph   <= '0;
    end else if (tick && tx_busy) begin
      tx_ph <= tx_ph + 1'b1;
      if (tx_ph == `ASL_LAST_PH) begin
        // idle and stop level is one
        tx_sh   <= {1'b1, tx_sh[10:1]};
        tx_bits <= tx_bits - 1'b1;
      end
    end
  end

  // back to back; a halt aborts the frame at any point once started
  // loads only on a tick so every bit lasts exactly sixteen ticks
  always_comb begin
    tx_load = 1'b0;
    tx_byte = `ASL_HDR;
    fifo_rd = 1'b0;
    unique case (st)
      ST_IDLE: tx_load = tick && fifo_v && !lk.h_rts && !o_tx_hold && !tx_busy && !halt;
      ST_DATA: begin
        fifo_rd = tick && fifo_v && !tx_busy && !halt;
        tx_load = fifo_rd;
        tx_byte = fifo_q[7:0];
      end
      ST_CHK: begin
        tx_load = tick && !tx_busy && !halt;
        tx_byte = 8'h00 - tx_sum;
      end
      ST_FIN: tx_load = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st     <= ST_IDLE;
      tx_sum <= '0;
      tx_end <= 1'b0;
    end else if (halt) begin
      st     <= ST_IDLE;
      tx_sum <= '0;
      tx_end <= 1'b0;
    end else begin
      tx_end <= 1'b0;
      unique case (st)
        ST_IDLE: if (tx_load) begin
          st     <= ST_DATA;
          tx_sum <= '0;
        end
        ST_DATA: if (fifo_rd) begin
          tx_sum <= tx_sum + fifo_q[7:0];
          if (fifo_q[8]) begin
            st <= ST_CHK;
          end
        end
        ST_CHK: if (tx_load) begin
          st <= ST_FIN;
        end
        ST_FIN: if (!tx_busy) begin
          st     <= ST_IDLE;
          tx_end <= 1'b1;
        end
      endcase
    end
  end

  assign rx_done     = tick && (rx_bits == 4'h1) && (rx_ph == `ASL_SAMPLE_PH);
  assign rx_byte     = rx_sh[9:2];
  assign rx_bad_char = (^rx_sh[10:2]) || !lk.h_txd;
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rx_sh   <= '1;
      rx_bits <= '0;
      rx_ph   <= '0;
    end else if (tick) begin
      if (rx_bits == '0) begin
        if (!lk.h_txd) begin
          rx_bits <= `ASL_CHAR_BITS;
          rx_ph   <= 4'h1;
        end
      end else begin
        rx_ph <= rx_ph + 1'b1;
        if (rx_ph == `ASL_SAMPLE_PH) begin
          rx_sh   <= {lk.h_txd, rx_sh[10:1]};
          rx_bits <= (rx_bits == `ASL_CHAR_BITS && lk.h_txd) ? 4'h0 : rx_bits - 1'b1;
        end
      end
    end
  end

  assign rx_end = in_frame && (gap_cnt == GAP_CYC - 24'h1);
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      gap_cnt <= '0;
    end else if (rx_bits != '0) begin
      gap_cnt <= '0;
    end else if (gap_cnt != GAP_CYC) begin
      gap_cnt <= gap_cnt + 24'h1;
    end
  end

  // frame checking; checksum byte held back, never delivered
  assign good_end = rx_end && !bad && !hdr_bad && have_pend && (rx_sum == 8'h00);
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      in_frame    <= 1'b0;
      hdr_bad     <= 1'b0;
      bad         <= 1'b0;
      rx_sum      <= '0;
      have_pend   <= 1'b0;
      pend        <= '0;
      o_rx_data   <= '0;
      o_rx_valid  <= 1'b0;
      o_rx_done   <= 1'b0;
      o_rx_good   <= 1'b0;
      o_frame_err <= 1'b0;
    end else begin
      o_rx_valid  <= 1'b0;
      o_rx_done   <= 1'b0;
      o_frame_err <= rx_done && !lk.h_txd;
      if (halt) begin
        in_frame <= 1'b0;
      end else if (rx_done && !in_frame) begin
        in_frame  <= 1'b1;
        hdr_bad   <= (rx_byte != `ASL_HDR);
        bad       <= rx_bad_char;
        rx_sum    <= '0;
        have_pend <= 1'b0;
      end else if (rx_done) begin
        bad       <= bad || rx_bad_char;
        rx_sum    <= rx_sum + rx_byte;
        pend      <= rx_byte;
        have_pend <= 1'b1;
        if (have_pend) begin
          o_rx_data  <= pend;
          o_rx_valid <= 1'b1;
        end
      end else if (rx_end) begin
        in_frame  <= 1'b0;
        o_rx_done <= 1'b1;
        o_rx_good <= good_end;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      lk.a_rts <= 1'b1;
    end else begin
      lk.a_rts <= i_rx_hold || halt;
    end
  end

  // timeout and retransmit hold; recovery is left to the user
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      resp_cnt       <= '0;
      pending        <= 1'b0;
      o_resp_timeout <= 1'b0;
    end else if (halt) begin
      resp_cnt       <= '0;
      pending        <= 1'b0;
      o_resp_timeout <= 1'b0;
    end else begin
      o_resp_timeout <= pending && (resp_cnt == 24'h1) && !good_end && !tx_end;
      if (tx_end) begin
        resp_cnt <= RESP_CYC;
        pending  <= 1'b1;
      end else begin
        if (resp_cnt != '0) begin
          resp_cnt <= resp_cnt - 24'h1;
        end
        if (good_end || resp_cnt == 24'h1) begin
          pending <= 1'b0;
        end
      end
    end
  end
endmodule

/* inc/asl_cfg.svh */
/*
  Constants of the adapter serial link: character layout, frame bytes,
  bit-rate dividers and timing counts.
  Assumes a 50 MHz system clock on both ends.
*/
`ifndef ASL_CFG_SVH
`define ASL_CFG_SVH
`define ASL_CLK_HZ     50000000
`define ASL_BAUD_LO    2400
`define ASL_BAUD_HI    9600
`define ASL_OVS        16
`define ASL_DIV_LO     (`ASL_CLK_HZ / (`ASL_BAUD_LO * `ASL_OVS))
`define ASL_DIV_HI     (`ASL_CLK_HZ / (`ASL_BAUD_HI * `ASL_OVS))
`define ASL_CHAR_BITS  4'hB
`define ASL_SAMPLE_PH  4'h7
`define ASL_LAST_PH    4'hF
`define ASL_HDR        8'h02
`define ASL_GAP_MS     10
`define ASL_GAP_CYC    (`ASL_CLK_HZ / 1000 * `ASL_GAP_MS)
`define ASL_RESP_MS    300
`define ASL_RESP_CYC   (`ASL_CLK_HZ / 1000 * `ASL_RESP_MS)
`define ASL_FIFO_DEPTH 8
`define ASL_FIFO_WIDTH 9
`endif

/* inc/asl_pkg.sv */
/*
  Types shared by both ends of the adapter serial link.
  Assumes asl_cfg.svh for the numeric constants.
*/
package asl_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DATA = 4'h2,
    ST_CHK  = 4'h4,
    ST_FIN  = 4'h8
  } asl_txst_t;
endpackage

/* inc/asl_if.sv */
/*
  Link between the adapter and the host equipment: two data lines,
  two flow-control lines and the adapter reset line.
  Assumes the testbench joins the two ends through one instance.
*/
`timescale 1ns/100ps
interface asl_if;
  logic a_txd;
  logic h_txd;
  logic a_rts;
  logic h_rts;
  logic h_rst_n;
  modport adapter (
    input  h_txd,
    input  h_rts,
    input  h_rst_n,
    output a_txd,
    output a_rts
  );
  modport host (
    input  a_txd,
    input  a_rts,
    output h_txd,
    output h_rts,
    output h_rst_n
  );
endinterface

/* hdl/asl_fifo.sv */
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module asl_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_reset,
  // fill side
  input  wire logic [W-1:0] i_wr_data,
  input  wire logic         i_wr_valid,
  output logic              o_wr_ready,
  // drain side
  output logic [W-1:0]      o_rd_data,
  output logic              o_rd_valid,
  input  wire logic         i_rd_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          wr;
  logic          rd;

  assign o_wr_ready = (cnt != (AW+1)'(D));
  assign o_rd_valid = (cnt != '0);
  assign o_rd_data  = mem[rp];
  assign wr = i_wr_valid && o_wr_ready;
  assign rd = o_rd_valid && i_rd_ready;

  always_ff @(posedge i_mclk) begin
    if (wr) begin
      mem[wp] <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (wr) begin
        wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      end
      if (rd) begin
        rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

/* hdl/asl_host.sv */
/*
  Host equipment end of the serial link: answers adapter frames with
  header and checksum framing, honours CTS and the idle frame gap,
  and drives the adapter reset line.
  Assumes link inputs are synchronous to i_mclk.
*/
`timescale 1ns/100ps
`include "asl_cfg.svh"
module asl_host import asl_pkg::*; #(
  parameter logic [23:0] GAP_CYC = 24'(`ASL_GAP_CYC),
  parameter logic [10:0] DIV_HI  = 11'(`ASL_DIV_HI - 1)
) (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // link
  asl_if.host             lk,
  // configuration and adapter reset request
  input  wire logic       i_baud_hi,
  input  wire logic       i_adapter_reset,
  // transmit data part
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_last,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  // receive data part
  input  wire logic       i_rx_hold,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_done,
  output logic            o_rx_good
);
  localparam logic [10:0] DIV_LO = 11'(`ASL_DIV_LO - 1);

  logic [10:0] div_cnt;
  logic        tick;
  logic [10:0] tx_sh;
  logic [3:0]  tx_bits;
  logic [3:0]  tx_ph;
  logic        tx_busy;
  logic        tx_load;
  logic [7:0]  tx_byte;
  asl_txst_t   st;
  logic [7:0]  tx_sum;
  logic [10:0] rx_sh;
  logic [3:0]  rx_bits;
  logic [3:0]  rx_ph;
  logic        rx_done;
  logic [7:0]  rx_byte;
  logic [23:0] gap_cnt;
  logic        in_frame;
  logic        bad;
  logic [7:0]  rx_sum;
  logic        have_pend;
  logic [7:0]  pend;
  logic        may_start;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      div_cnt    <= '0;
      tick       <= 1'b0;
      lk.h_rst_n <= 1'b0;
      lk.h_rts   <= 1'b1;
    end else begin
      lk.h_rst_n <= !i_adapter_reset;
      lk.h_rts   <= i_rx_hold;
      tick       <= (div_cnt == '0);
      div_cnt    <= (div_cnt == '0) ? (i_baud_hi ? DIV_HI : DIV_LO) : div_cnt - 1'b1;
    end
  end

  assign tx_busy = (tx_bits != '0);
  assign lk.h_txd = tx_sh[0];
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      tx_sh   <= '1;
      tx_bits <= '0;
      tx_ph   <= '0;
    end else if (tx_load) begin
      tx_sh   <= {1'b1, ^tx_byte, tx_byte, 1'b0};
      tx_bits <= `ASL_CHAR_BITS;
      tx_ph   <= '0;
    end else if (tick && tx_busy) begin
      tx_ph <= tx_ph + 1'b1;
      if (tx_ph == `ASL_LAST_PH) begin
        tx_sh   <= {1'b1, tx_sh[10:1]};
        tx_bits <= tx_bits - 1'b1;
      end
    end
  end

  // adapter first: answers only after a full idle gap
  assign may_start = (gap_cnt == GAP_CYC) && !in_frame && (rx_bits == '0) && !lk.a_rts;
  always_comb begin
    tx_load    = 1'b0;
    tx_byte    = `ASL_HDR;
    o_tx_ready = 1'b0;
    unique case (st)
      ST_IDLE: tx_load = tick && i_tx_valid && may_start && !tx_busy;
      ST_DATA: begin
        o_tx_ready = tick && !tx_busy;
        tx_load    = tick && i_tx_valid && !tx_busy;
        tx_byte    = i_tx_data;
      end
      ST_CHK: begin
        tx_load = tick && !tx_busy;
        tx_byte = 8'h00 - tx_sum;
      end
      ST_FIN: tx_load = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st     <= ST_IDLE;
      tx_sum <= '0;
    end else begin
      unique case (st)
        ST_IDLE: if (tx_load) begin
          st     <= ST_DATA;
          tx_sum <= '0;
        end
        ST_DATA: if (tx_load) begin
          tx_sum <= tx_sum + i_tx_data;
          if (i_tx_last) begin
            st <= ST_CHK;
          end
        end
        ST_CHK: if (tx_load) begin
          st <= ST_FIN;
        end
        ST_FIN: if (!tx_busy) begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  assign rx_done = tick && (rx_bits == 4'h1) && (rx_ph == `ASL_SAMPLE_PH);
  assign rx_byte = rx_sh[9:2];
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rx_sh   <= '1;
      rx_bits <= '0;
      rx_ph   <= '0;
    end else if (tick) begin
      if (rx_bits == '0) begin
        if (!lk.a_txd) begin
          rx_bits <= `ASL_CHAR_BITS;
          rx_ph   <= 4'h1;
        end
      end else begin
        rx_ph <= rx_ph + 1'b1;
        if (rx_ph == `ASL_SAMPLE_PH) begin
          rx_sh   <= {lk.a_txd, rx_sh[10:1]};
          rx_bits <= (rx_bits == `ASL_CHAR_BITS && lk.a_txd) ? 4'h0 : rx_bits - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      gap_cnt <= '0;
    end else if (rx_bits != '0) begin
      gap_cnt <= '0;
    end else if (gap_cnt != GAP_CYC) begin
      gap_cnt <= gap_cnt + 24'h1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      in_frame   <= 1'b0;
      bad        <= 1'b0;
      rx_sum     <= '0;
      have_pend  <= 1'b0;
      pend       <= '0;
      o_rx_data  <= '0;
      o_rx_valid <= 1'b0;
      o_rx_done  <= 1'b0;
      o_rx_good  <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      o_rx_done  <= 1'b0;
      if (rx_done && !in_frame) begin
        in_frame  <= 1'b1;
        bad       <= (rx_byte != `ASL_HDR) || (^rx_sh[10:2]) || !lk.a_txd;
        rx_sum    <= '0;
        have_pend <= 1'b0;
      end else if (rx_done) begin
        bad       <= bad || (^rx_sh[10:2]) || !lk.a_txd;
        rx_sum    <= rx_sum + rx_byte;
        pend      <= rx_byte;
        have_pend <= 1'b1;
        if (have_pend) begin
          o_rx_data  <= pend;
          o_rx_valid <= 1'b1;
        end
      end else if (in_frame && gap_cnt == GAP_CYC - 24'h1) begin
        in_frame  <= 1'b0;
        o_rx_done <= 1'b1;
        o_rx_good <= !bad && have_pend && (rx_sum == 8'h00);
      end
    end
  end
endmodule

/* verification/asl_link_asserts.sv */
/*
  Wire checker for the adapter/host link: bit timing, flow control,
  halt, hold and response spacing.
  Assumes 9600 bps on both ends and one 50 MHz clock.
*/
`timescale 1ns/100ps
module asl_link_asserts #(
  parameter int GAP_CYC  = 80000,
  parameter int RESP_CYC = 200000,
  parameter int BIT_CYC  = 5200
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // link lines
  input wire logic a_txd,
  input wire logic h_txd,
  input wire logic a_rts,
  input wire logic h_rts,
  input wire logic h_rst_n
);
  localparam int CHR_CYC = 11 * BIT_CYC;
  int   a_lo;
  int   h_lo;
  int   a_hi;
  int   h_hi;
  int   ac_hi;
  logic a_sent;
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      a_lo <= 0;
      h_lo <= 0;
      a_hi <= 0;
      h_hi <= 0;
      ac_hi <= 0;
      a_sent <= 1'b0;
    end else begin
      a_lo <= a_txd ? 0 : a_lo + 1;
      h_lo <= h_txd ? 0 : h_lo + 1;
      a_hi <= a_txd ? a_hi + 1 : 0;
      h_hi <= h_txd ? h_hi + 1 : 0;
      ac_hi <= h_rts ? ac_hi + 1 : 0;
      a_sent <= a_sent | !a_txd;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // a new frame follows more than a character time of idle line
  sequence a_start;
    $fell(a_txd) && a_hi > CHR_CYC;
  endsequence
  sequence h_start;
    $fell(h_txd) && h_hi > CHR_CYC;
  endsequence
  rst_rts_a: assert property (!h_rst_n |=> a_rts)
    else $error("adapter rts low during halt");
  halt_idle_a: assert property (!h_rst_n [*2] |-> a_txd)
    else $error("adapter sends during halt");
  a_cts_a: assert property (a_start |-> ac_hi < 1000)
    else $error("adapter frame started while cts high");
  h_cts_a: assert property (h_start |-> !$past(a_rts))
    else $error("host frame started while cts high");
  a_bits_a: assert property ($rose(a_txd) |-> a_lo % BIT_CYC == 0 && a_lo <= 10 * BIT_CYC)
    else $error("adapter bit timing wrong");
  h_bits_a: assert property ($rose(h_txd) |-> h_lo % BIT_CYC == 0 && h_lo <= 10 * BIT_CYC)
    else $error("host bit timing wrong");
  a_hold_a: assert property ($fell(a_txd) && a_sent |-> a_hi < GAP_CYC || a_hi > RESP_CYC)
    else $error("adapter retransmit too early");
  h_wait_a: assert property (h_start |-> a_txd && a_hi >= GAP_CYC)
    else $error("host response too early");
endmodule

/* verification/tb.sv */
/*
  Bench: adapter and host joined by one link, driven from both user sides.
  Assumes the high bit-rate setting and shortened divider, gap and response counts.
*/
`timescale 1ns/100ps
`include "asl_cfg.svh"
module tb;
  // divider shortened to five clocks a tick to keep the run short
  localparam int GAP  = 4000;
  localparam int RESP = 20000;
  localparam int BIT  = 80;
  logic        i_mclk;
  logic        i_reset;
  logic        a_hold;
  logic        h_hold;
  logic        arst_req;
  logic [7:0]  tx_d [2];
  logic        tx_l [2];
  logic        tx_v [2];
  logic        a_tx_ready, a_rx_valid, a_rx_done, a_rx_good, a_ferr;
  logic        a_tout, a_tx_hold, a_rst_go;
  logic        h_tx_ready, h_rx_valid, h_rx_done, h_rx_good;
  logic [7:0]  a_rx_data, h_rx_data;
  logic [10:0] a_ch [$];
  logic [10:0] h_ch [$];
  logic [7:0]  a_by [$];
  logic [7:0]  h_by [$];
  int          n_mismatch, samples_checked, n_ferr, n;
  asl_if lk ();
  asl_adapter #(.GAP_CYC(24'(GAP)), .RESP_CYC(24'(RESP)), .DEPTH(8),
    .DIV_HI(11'h004)) asl_adapter_i (
    .i_mclk(i_mclk), .i_reset(i_reset), .lk(lk), .i_baud_hi(1'b1),
    .i_tx_data(tx_d[0]), .i_tx_last(tx_l[0]), .i_tx_valid(tx_v[0]),
    .o_tx_ready(a_tx_ready), .i_rx_hold(a_hold), .o_rx_data(a_rx_data),
    .o_rx_valid(a_rx_valid), .o_rx_done(a_rx_done), .o_rx_good(a_rx_good),
    .o_frame_err(a_ferr), .o_resp_timeout(a_tout), .o_tx_hold(a_tx_hold),
    .o_reset_start(a_rst_go));
  asl_host #(.GAP_CYC(24'(GAP)), .DIV_HI(11'h004)) asl_host_i (
    .i_mclk(i_mclk), .i_reset(i_reset), .lk(lk), .i_baud_hi(1'b1),
    .i_adapter_reset(arst_req), .i_tx_data(tx_d[1]), .i_tx_last(tx_l[1]),
    .i_tx_valid(tx_v[1]), .o_tx_ready(h_tx_ready), .i_rx_hold(h_hold),
    .o_rx_data(h_rx_data), .o_rx_valid(h_rx_valid), .o_rx_done(h_rx_done),
    .o_rx_good(h_rx_good));
  asl_link_asserts #(.GAP_CYC(GAP), .RESP_CYC(RESP), .BIT_CYC(BIT)) chk_i (
    .i_mclk(i_mclk), .i_reset(i_reset), .a_txd(lk.a_txd), .h_txd(lk.h_txd),
    .a_rts(lk.a_rts), .h_rts(lk.h_rts), .h_rst_n(lk.h_rst_n));
  function automatic logic [10:0] chr(input logic [7:0] b);
    return {1'b1, ^b, b, 1'b0};
  endfunction
  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic send(input int h, input logic [7:0] d, input logic l);
    logic r;
    r = 1'b0;
    tx_d[h] <= d;
    tx_l[h] <= l;
    tx_v[h] <= 1'b1;
    for (int i = 0; i < 400000 && r !== 1'b1; i++) begin
      @(negedge i_mclk);
      r = h ? h_tx_ready : a_tx_ready;
      @(posedge i_mclk);
    end
    tx_v[h] <= 1'b0;
    check("write accepted", r, 1);
    @(posedge i_mclk);
  endtask
  task automatic wait_sig(input int s, input int lim);
    logic v;
    v = 1'b0;
    for (n = 0; n < lim && v !== 1'b1; n++) begin
      @(negedge i_mclk);
      case (s)
        0: v = a_rst_go;
        1: v = h_rx_done;
        2: v = a_tout;
        default: v = a_rx_done;
      endcase
    end
    if (v !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // line sampled at each bit centre, start bit first
  task automatic grab(input bit h);
    logic [10:0] c;
    forever begin
      @(posedge i_mclk);
      if ((h ? lk.h_txd : lk.a_txd) === 1'b0) begin
        repeat (BIT / 2 - 1) @(posedge i_mclk);
        for (int k = 0; k < 11; k++) begin
          c[k] = h ? lk.h_txd : lk.a_txd;
          if (k < 10) repeat (BIT) @(posedge i_mclk);
        end
        if (h) h_ch.push_back(c);
        else a_ch.push_back(c);
      end
    end
  endtask
  task automatic chk_frame(input bit h, input logic [7:0] d);
    logic [7:0] ex [3];
    ex = '{`ASL_HDR, d, 8'(8'h00 - d)};
    check("char count", h ? h_ch.size() : a_ch.size(), 3);
    for (int k = 0; k < 3; k++) begin
      check("char", h ? h_ch[k] : a_ch[k], chr(ex[k]));
    end
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial grab(1'b0);
  initial grab(1'b1);
  always @(negedge i_mclk) begin
    if (a_rx_valid === 1'b1) a_by.push_back(a_rx_data);
    if (h_rx_valid === 1'b1) h_by.push_back(h_rx_data);
    if (a_ferr !== 1'b0) n_ferr++;
  end
  initial begin
    i_reset = 1'b1;
    a_hold = 1'b0;
    h_hold = 1'b0;
    arst_req = 1'b0;
    tx_d = '{8'h00, 8'h00};
    tx_l = '{1'b0, 1'b0};
    tx_v = '{1'b0, 1'b0};
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    arst_req <= 1'b1;
    repeat (5) @(posedge i_mclk);
    check("halt rts", lk.a_rts, 1);
    arst_req <= 1'b0;
    wait_sig(0, 20);
    a_hold <= 1'b1;
    h_hold <= 1'b1;
    repeat (3) @(posedge i_mclk);
    check("adapter rts", lk.a_rts, 1);
    check("host rts", lk.h_rts, 1);
    a_hold <= 1'b0;
    for (int i = 0; i < 8; i++) send(0, 8'(8'h10 + i), 1'b0);
    @(negedge i_mclk);
    check("fifo full", a_tx_ready, 0);
    repeat (3) @(posedge i_mclk);
    check("adapter rts free", lk.a_rts, 0);
    repeat (3000) @(posedge i_mclk);
    check("no send under cts", a_ch.size(), 0);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(negedge i_mclk);
    check("fifo flushed", a_tx_ready, 1);
    @(posedge i_mclk);
    h_hold <= 1'b0;
    send(0, 8'hA5, 1'b1);
    wait_sig(1, 400000);
    check("host rx good", h_rx_good, 1);
    check("host rx byte", {h_by.size(), h_by[0]}, {32'd1, 8'hA5});
    check("tx hold", a_tx_hold, 1);
    chk_frame(0, 8'hA5);
    wait_sig(2, RESP);
    check("timeout span", n > RESP - GAP - BIT && n < RESP - GAP + BIT, 1);
    send(1, 8'h3C, 1'b1);
    wait_sig(3, 400000);
    check("adapter rx good", a_rx_good, 1);
    check("adapter rx byte", {a_by.size(), a_by[0]}, {32'd1, 8'h3C});
    chk_frame(1, 8'h3C);
    check("stop bit errors", n_ferr, 0);
    complete_run();
  end
endmodule
